// ---- core/ppsh_pin_sharing.sv ----
`timescale 1ns/1ps
module ppsh_pin_sharing (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [ppsh_pkg::M_W-1:0] port_group_m_pad_in,
  output logic [ppsh_pkg::M_W-1:0] port_group_m_pad_out,
  output logic [ppsh_pkg::M_W-1:0] port_group_m_pad_oe_n_out,
  input wire logic [ppsh_pkg::L_W-1:0] port_group_l_pad_in,
  output logic [ppsh_pkg::L_W-1:0] port_group_l_pad_out,
  output logic [ppsh_pkg::L_W-1:0] port_group_l_pad_oe_n_out,
  input wire logic [ppsh_pkg::K_W-1:0] port_group_k_pad_in,
  output logic [ppsh_pkg::K_W-1:0] port_group_k_pad_out,
  output logic [ppsh_pkg::K_W-1:0] port_group_k_pad_oe_n_out,
  input wire logic [ppsh_pkg::J_W-1:0] port_group_j_pad_in,
  output logic [ppsh_pkg::J_W-1:0] port_group_j_pad_out,
  output logic [ppsh_pkg::J_W-1:0] port_group_j_pad_oe_n_out,
  input wire logic [ppsh_pkg::I_W-1:0] port_group_i_pad_in,
  output logic [ppsh_pkg::I_W-1:0] port_group_i_pad_out,
  output logic [ppsh_pkg::I_W-1:0] port_group_i_pad_oe_n_out,
  input wire logic [ppsh_pkg::M_W-1:0] port_group_m_data_in,
  input wire logic [ppsh_pkg::M_W-1:0] port_group_m_dir_in,
  input wire logic [ppsh_pkg::L_W-1:0] port_group_l_data_in,
  input wire logic [ppsh_pkg::L_W-1:0] port_group_l_dir_in,
  input wire logic [ppsh_pkg::K_W-1:0] port_group_k_data_in,
  input wire logic [ppsh_pkg::K_W-1:0] port_group_k_dir_in,
  input wire logic [ppsh_pkg::J_W-1:0] port_group_j_data_in,
  input wire logic [ppsh_pkg::J_W-1:0] port_group_j_dir_in,
  input wire logic [ppsh_pkg::I_W-1:0] port_group_i_data_in,
  input wire logic [ppsh_pkg::I_W-1:0] port_group_i_dir_in,
  output logic [ppsh_pkg::PAD_TOTAL-1:0] port_pad_level_out,
  input wire logic sync_serial_rx_en_in,
  input wire logic sync_serial_tx_en_in,
  input wire logic sync_serial_tx_data_in,
  input wire logic sync_serial_ext_clk_mode_in,
  input wire logic sync_serial_clk_oe_in,
  input wire logic sync_serial_clk_drive_in,
  output logic sync_serial_rx_out,
  output logic sync_serial_shift_clock_out,
  input wire logic updown_counter_en_in,
  output logic updown_counter_phase_a_out,
  output logic updown_counter_phase_b_out,
  output logic updown_counter_zero_out,
  input wire logic [ppsh_pkg::TRG_W-1:0] pulse_gen_trig_en_in,
  output logic [ppsh_pkg::TRG_W-1:0] pulse_gen_ext_trigger_out,
  input wire logic two_wire_en_in,
  input wire logic two_wire_sda_low_in,
  input wire logic two_wire_scl_low_in,
  output logic two_wire_sda_out,
  output logic two_wire_scl_out,
  input wire logic [ppsh_pkg::IRQ_W-1:0] ext_irq_en_in,
  output logic [ppsh_pkg::IRQ_W-1:0] ext_interrupt_inputs_out,
  input wire logic freerun_ext_clk_sel_in,
  output logic freerun_ext_clock_out,
  input wire logic converter_trig_sel_in,
  output logic converter_ext_trigger_out,
  input wire logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_tx_en_in,
  input wire logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_tx_data_in,
  input wire logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_clk_oe_in,
  input wire logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_clk_drive_in,
  input wire logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_ext_clk_in,
  output logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_rx_data_out,
  output logic [ppsh_pkg::ASYNC_CH-1:0] async_serial_clock_pin_out
);
  // ****************************************************
  // pad sampling
  // ****************************************************
  logic [ppsh_pkg::PAD_TOTAL-1:0] pad_raw;
  logic [ppsh_pkg::PAD_TOTAL-1:0] pad_sync;
  logic [ppsh_pkg::M_W-1:0] m_sync;
  logic [ppsh_pkg::L_W-1:0] l_sync;
  logic [ppsh_pkg::K_W-1:0] k_sync;
  logic [ppsh_pkg::J_W-1:0] j_sync;
  logic [ppsh_pkg::I_W-1:0] i_sync;

  assign pad_raw = {port_group_i_pad_in, port_group_j_pad_in, port_group_k_pad_in,
                    port_group_l_pad_in, port_group_m_pad_in};

  ppsh_sync2 #(.W(ppsh_pkg::PAD_TOTAL)) ppsh_sync2_i (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .async_in(pad_raw),
    .sync_out(pad_sync)
  );

  assign m_sync = pad_sync[ppsh_pkg::M_LSB +: ppsh_pkg::M_W];
  assign l_sync = pad_sync[ppsh_pkg::L_LSB +: ppsh_pkg::L_W];
  assign k_sync = pad_sync[ppsh_pkg::K_LSB +: ppsh_pkg::K_W];
  assign j_sync = pad_sync[ppsh_pkg::J_LSB +: ppsh_pkg::J_W];
  assign i_sync = pad_sync[ppsh_pkg::I_LSB +: ppsh_pkg::I_W];

  // ****************************************************
  // pad drive decode, result is {out, oe_n}
  // ****************************************************
  function automatic logic [1:0] pad_drive(input logic drive, input logic drv_val,
                                           input logic claim_in, input logic data,
                                           input logic dir);
    logic [1:0] res;
    if (drive) begin
      res = {drv_val, 1'b0};
    end else if (claim_in) begin
      res = {ppsh_pkg::PAD_OUT_RST, 1'b1};
    end else begin
      res = {data, ~dir};
    end
    return res;
  endfunction

  function automatic logic [1:0] od_drive(input logic pull_low);
    return {ppsh_pkg::OD_LEVEL, ~pull_low};
  endfunction

  // ****************************************************
  // async serial channels
  // ****************************************************
  logic [ppsh_pkg::I_W-1:0] i_out_w;
  logic [ppsh_pkg::I_W-1:0] i_oe_n_w;
  logic [ppsh_pkg::ASYNC_CH-1:0] a_rx_w;
  logic [ppsh_pkg::ASYNC_CH-1:0] a_clk_w;

  for (genvar c = 0; c < ppsh_pkg::ASYNC_CH; c++) begin : g_async
    localparam int RX = c * ppsh_pkg::ASYNC_PINS + ppsh_pkg::ASYNC_RX_OFS;
    localparam int TX = c * ppsh_pkg::ASYNC_PINS + ppsh_pkg::ASYNC_TX_OFS;
    localparam int CK = c * ppsh_pkg::ASYNC_PINS + ppsh_pkg::ASYNC_CLK_OFS;
    // rx pin stays a port pin, software keeps its driver off
    assign {i_out_w[RX], i_oe_n_w[RX]} = pad_drive(1'b0, 1'b0, 1'b0,
                                         port_group_i_data_in[RX], port_group_i_dir_in[RX]);
    assign {i_out_w[TX], i_oe_n_w[TX]} = pad_drive(async_serial_tx_en_in[c],
                                         async_serial_tx_data_in[c], 1'b0,
                                         port_group_i_data_in[TX], port_group_i_dir_in[TX]);
    assign {i_out_w[CK], i_oe_n_w[CK]} = pad_drive(async_serial_clk_oe_in[c],
                                         async_serial_clk_drive_in[c],
                                         async_serial_ext_clk_in[c],
                                         port_group_i_data_in[CK], port_group_i_dir_in[CK]);
    assign a_rx_w[c] = i_sync[RX];
    assign a_clk_w[c] = async_serial_ext_clk_in[c] & i_sync[CK];
  end

  // ****************************************************
  // next values
  // ****************************************************
  logic [ppsh_pkg::M_W-1:0] nxt_m_out, nxt_m_oe_n;
  logic [ppsh_pkg::L_W-1:0] nxt_l_out, nxt_l_oe_n;
  logic [ppsh_pkg::K_W-1:0] nxt_k_out, nxt_k_oe_n;
  logic [ppsh_pkg::J_W-1:0] nxt_j_out, nxt_j_oe_n;
  logic [ppsh_pkg::I_W-1:0] nxt_i_out, nxt_i_oe_n;
  logic nxt_ss_rx, nxt_ss_clk, nxt_ud_a, nxt_ud_b, nxt_ud_z;
  logic [ppsh_pkg::TRG_W-1:0] nxt_trg;
  logic nxt_sda, nxt_scl, nxt_frclk, nxt_conv;
  logic [ppsh_pkg::IRQ_W-1:0] nxt_irq;
  logic m_claim;

  always_comb begin
    m_claim = sync_serial_rx_en_in | updown_counter_en_in | (|pulse_gen_trig_en_in);
    {nxt_m_out[ppsh_pkg::M_RX_BIT], nxt_m_oe_n[ppsh_pkg::M_RX_BIT]} = pad_drive(1'b0, 1'b0,
      m_claim, port_group_m_data_in[ppsh_pkg::M_RX_BIT],
      port_group_m_dir_in[ppsh_pkg::M_RX_BIT]);
    {nxt_m_out[ppsh_pkg::M_TX_BIT], nxt_m_oe_n[ppsh_pkg::M_TX_BIT]} = pad_drive(
      sync_serial_tx_en_in, sync_serial_tx_data_in, m_claim,
      port_group_m_data_in[ppsh_pkg::M_TX_BIT],
      port_group_m_dir_in[ppsh_pkg::M_TX_BIT]);
    {nxt_m_out[ppsh_pkg::M_SCK_BIT], nxt_m_oe_n[ppsh_pkg::M_SCK_BIT]} = pad_drive(
      sync_serial_clk_oe_in, sync_serial_clk_drive_in,
      m_claim | sync_serial_ext_clk_mode_in, port_group_m_data_in[ppsh_pkg::M_SCK_BIT],
      port_group_m_dir_in[ppsh_pkg::M_SCK_BIT]);
    for (int b = 0; b < ppsh_pkg::L_W; b++) begin
      if (two_wire_en_in) begin
        {nxt_l_out[b], nxt_l_oe_n[b]} = od_drive(b == ppsh_pkg::L_SDA_BIT ?
                                        two_wire_sda_low_in : two_wire_scl_low_in);
      end else begin
        {nxt_l_out[b], nxt_l_oe_n[b]} = od_drive(port_group_l_dir_in[b] &
                                                 ~port_group_l_data_in[b]);
      end
    end
    nxt_k_out = port_group_k_data_in;
    nxt_k_oe_n = ~port_group_k_dir_in;
    nxt_j_out = port_group_j_data_in;
    nxt_j_oe_n = ~port_group_j_dir_in;
    nxt_i_out = i_out_w;
    nxt_i_oe_n = i_oe_n_w;
    nxt_ss_rx = sync_serial_rx_en_in & m_sync[ppsh_pkg::M_RX_BIT];
    nxt_ss_clk = sync_serial_ext_clk_mode_in & m_sync[ppsh_pkg::M_SCK_BIT];
    nxt_ud_a = updown_counter_en_in & m_sync[ppsh_pkg::M_RX_BIT];
    nxt_ud_b = updown_counter_en_in & m_sync[ppsh_pkg::M_TX_BIT];
    nxt_ud_z = updown_counter_en_in & m_sync[ppsh_pkg::M_SCK_BIT];
    nxt_trg = pulse_gen_trig_en_in & m_sync;
    nxt_sda = l_sync[ppsh_pkg::L_SDA_BIT];
    nxt_scl = l_sync[ppsh_pkg::L_SCL_BIT];
    nxt_irq = ext_irq_en_in & {j_sync, k_sync};
    nxt_frclk = freerun_ext_clk_sel_in & k_sync[ppsh_pkg::K_FRCLK_BIT];
    nxt_conv = converter_trig_sel_in & k_sync[ppsh_pkg::K_CONV_BIT];
  end

  // ****************************************************
  // output registers
  // ****************************************************
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      port_group_m_pad_out <= {ppsh_pkg::M_W{ppsh_pkg::PAD_OUT_RST}};
      port_group_m_pad_oe_n_out <= {ppsh_pkg::M_W{ppsh_pkg::PAD_OE_N_RST}};
      port_group_l_pad_out <= {ppsh_pkg::L_W{ppsh_pkg::PAD_OUT_RST}};
      port_group_l_pad_oe_n_out <= {ppsh_pkg::L_W{ppsh_pkg::PAD_OE_N_RST}};
      port_group_k_pad_out <= {ppsh_pkg::K_W{ppsh_pkg::PAD_OUT_RST}};
      port_group_k_pad_oe_n_out <= {ppsh_pkg::K_W{ppsh_pkg::PAD_OE_N_RST}};
      port_group_j_pad_out <= {ppsh_pkg::J_W{ppsh_pkg::PAD_OUT_RST}};
      port_group_j_pad_oe_n_out <= {ppsh_pkg::J_W{ppsh_pkg::PAD_OE_N_RST}};
      port_group_i_pad_out <= {ppsh_pkg::I_W{ppsh_pkg::PAD_OUT_RST}};
      port_group_i_pad_oe_n_out <= {ppsh_pkg::I_W{ppsh_pkg::PAD_OE_N_RST}};
      port_pad_level_out <= {ppsh_pkg::PAD_TOTAL{ppsh_pkg::SYNC_RST}};
      sync_serial_rx_out <= ppsh_pkg::SYNC_RST;
      sync_serial_shift_clock_out <= ppsh_pkg::SYNC_RST;
      updown_counter_phase_a_out <= ppsh_pkg::SYNC_RST;
      updown_counter_phase_b_out <= ppsh_pkg::SYNC_RST;
      updown_counter_zero_out <= ppsh_pkg::SYNC_RST;
      pulse_gen_ext_trigger_out <= {ppsh_pkg::TRG_W{ppsh_pkg::SYNC_RST}};
      two_wire_sda_out <= ppsh_pkg::SYNC_RST;
      two_wire_scl_out <= ppsh_pkg::SYNC_RST;
      ext_interrupt_inputs_out <= {ppsh_pkg::IRQ_W{ppsh_pkg::SYNC_RST}};
      freerun_ext_clock_out <= ppsh_pkg::SYNC_RST;
      converter_ext_trigger_out <= ppsh_pkg::SYNC_RST;
      async_serial_rx_data_out <= {ppsh_pkg::ASYNC_CH{ppsh_pkg::SYNC_RST}};
      async_serial_clock_pin_out <= {ppsh_pkg::ASYNC_CH{ppsh_pkg::SYNC_RST}};
    end else begin
      port_group_m_pad_out <= nxt_m_out;
      port_group_m_pad_oe_n_out <= nxt_m_oe_n;
      port_group_l_pad_out <= nxt_l_out;
      port_group_l_pad_oe_n_out <= nxt_l_oe_n;
      port_group_k_pad_out <= nxt_k_out;
      port_group_k_pad_oe_n_out <= nxt_k_oe_n;
      port_group_j_pad_out <= nxt_j_out;
      port_group_j_pad_oe_n_out <= nxt_j_oe_n;
      port_group_i_pad_out <= nxt_i_out;
      port_group_i_pad_oe_n_out <= nxt_i_oe_n;
      port_pad_level_out <= pad_sync;
      sync_serial_rx_out <= nxt_ss_rx;
      sync_serial_shift_clock_out <= nxt_ss_clk;
      updown_counter_phase_a_out <= nxt_ud_a;
      updown_counter_phase_b_out <= nxt_ud_b;
      updown_counter_zero_out <= nxt_ud_z;
      pulse_gen_ext_trigger_out <= nxt_trg;
      two_wire_sda_out <= nxt_sda;
      two_wire_scl_out <= nxt_scl;
      ext_interrupt_inputs_out <= nxt_irq;
      freerun_ext_clock_out <= nxt_frclk;
      converter_ext_trigger_out <= nxt_conv;
      async_serial_rx_data_out <= a_rx_w;
      async_serial_clock_pin_out <= a_clk_w;
    end
  end

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);

  a_async_tx_route: assert property (
    async_serial_tx_en_in[0] |=> port_group_i_pad_out[1] == $past(async_serial_tx_data_in[0])
      && !port_group_i_pad_oe_n_out[1])
    else $error("async tx pin not routed");
  a_async_clk_claim: assert property (
    (async_serial_ext_clk_in[0] && !async_serial_clk_oe_in[0])
      |=> port_group_i_pad_oe_n_out[2])
    else $error("async clock pin driven while external");
  a_two_wire_od: assert property (
    two_wire_en_in |=> !port_group_l_pad_out[0]
      && port_group_l_pad_oe_n_out[0] == !$past(two_wire_sda_low_in))
    else $error("two-wire data pin not open drain");
  a_two_wire_port: assert property (
    !two_wire_en_in |=> port_group_l_pad_oe_n_out[1]
      == !($past(port_group_l_dir_in[1]) && !$past(port_group_l_data_in[1])))
    else $error("two-wire clock port bit wrong");
  a_shared_in_free: assert property (
    (sync_serial_rx_en_in || updown_counter_en_in) |=> port_group_m_pad_oe_n_out[0])
    else $error("shared input pin driven");
  a_irq_sample: assert property (
    $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in) |-> ext_interrupt_inputs_out
      == ($past(ext_irq_en_in) & $past({port_group_j_pad_in, port_group_k_pad_in}, 3)))
    else $error("interrupt sample mismatch");
  a_frclk_gate: assert property (
    !freerun_ext_clk_sel_in |=> !freerun_ext_clock_out)
    else $error("free-run clock passed while unselected");
  a_conv_trig: assert property (
    $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in) && $past(converter_trig_sel_in)
      |-> converter_ext_trigger_out == $past(port_group_k_pad_in[7], 3))
    else $error("converter trigger not passed");
  a_sck_claim: assert property (
    sync_serial_clk_oe_in |=> !port_group_m_pad_oe_n_out[2]
      && port_group_m_pad_out[2] == $past(sync_serial_clk_drive_in))
    else $error("sync clock pin not driven");
  a_trig_pass: assert property (
    $past(rstn_in, 3) && $past(rstn_in, 2) && $past(rstn_in) |-> pulse_gen_ext_trigger_out
      == ($past(pulse_gen_trig_en_in) & $past(port_group_m_pad_in, 3)))
    else $error("pulse trigger mismatch");
  a_sync_tx_route: assert property (
    !sync_serial_tx_en_in ##1 !sync_serial_tx_en_in |-> port_group_m_pad_oe_n_out[1]
      || port_group_m_pad_out[1] == $past(port_group_m_data_in[1]))
    else $error("sync tx pin driven while off");
  a_port_follow: assert property (
    1'b1 |=> port_group_k_pad_out == $past(port_group_k_data_in)
      && port_group_k_pad_oe_n_out == ~$past(port_group_k_dir_in))
    else $error("port pins not following registers");

  c_async_tx: cover property (async_serial_tx_en_in[0] ##1 !async_serial_tx_en_in[0]);
  c_two_wire: cover property (two_wire_en_in && two_wire_sda_low_in);
  c_irq_hit: cover property (|ext_interrupt_inputs_out);
  c_sync_ext_clk: cover property (sync_serial_shift_clock_out);
endmodule

// ---- include/ppsh_pkg.sv ----
package ppsh_pkg;
  // ****************************************************
  // pad groups and their place in the synchronised vector
  // ****************************************************
  localparam int M_W = 3;
  localparam int L_W = 2;
  localparam int K_W = 8;
  localparam int J_W = 8;
  localparam int I_W = 6;
  localparam int M_LSB = 0;
  localparam int L_LSB = M_LSB + M_W;
  localparam int K_LSB = L_LSB + L_W;
  localparam int J_LSB = K_LSB + K_W;
  localparam int I_LSB = J_LSB + J_W;
  localparam int PAD_TOTAL = I_LSB + I_W;
  // ****************************************************
  // pin roles inside the groups
  // ****************************************************
  localparam int M_RX_BIT = 0;
  localparam int M_TX_BIT = 1;
  localparam int M_SCK_BIT = 2;
  localparam int L_SDA_BIT = 0;
  localparam int L_SCL_BIT = 1;
  localparam int K_FRCLK_BIT = 6;
  localparam int K_CONV_BIT = 7;
  localparam int IRQ_W = K_W + J_W;
  localparam int TRG_W = 3;
  localparam int ASYNC_CH = 2;
  localparam int ASYNC_PINS = 3;
  localparam int ASYNC_RX_OFS = 0;
  localparam int ASYNC_TX_OFS = 1;
  localparam int ASYNC_CLK_OFS = 2;
  // ****************************************************
  // reset values and open drain drive level
  // ****************************************************
  localparam logic PAD_OUT_RST = 1'b0;
  localparam logic PAD_OE_N_RST = 1'b1;
  localparam logic OD_LEVEL = 1'b0;
  localparam logic SYNC_RST = 1'b0;
endpackage

// ---- core/ppsh_sync2.sv ----
`timescale 1ns/1ps
module ppsh_sync2 #(
  parameter int W = 1
) (
  input wire logic clk_sys_in,
  input wire logic rstn_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  // ****************************************************
  // two stage synchroniser
  // ****************************************************
  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;
  logic [W-1:0] nxt_meta;
  logic [W-1:0] nxt_sync;

  always_comb begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_ff <= {W{ppsh_pkg::SYNC_RST}};
      sync_ff <= {W{ppsh_pkg::SYNC_RST}};
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign sync_out = sync_ff;
endmodule

// ---- test/ppsh_board_model.sv ----
`timescale 1ns/1ps
// ****************************************************
// board side of all shared pads, flat {i,j,k,l,m}
// ****************************************************
module ppsh_board_model #(
  parameter logic [ppsh_pkg::PAD_TOTAL-1:0] OD_MASK = '0
) (
  input wire logic [ppsh_pkg::PAD_TOTAL-1:0] pad_out_in,
  input wire logic [ppsh_pkg::PAD_TOTAL-1:0] pad_oe_n_in,
  input wire logic [ppsh_pkg::PAD_TOTAL-1:0] board_val_in,
  output logic [ppsh_pkg::PAD_TOTAL-1:0] pad_level_out
);
  always_comb begin
    for (int b = 0; b < ppsh_pkg::PAD_TOTAL; b++) begin
      if (!pad_oe_n_in[b]) begin
        // open drain pads only ever pull low
        pad_level_out[b] = OD_MASK[b] ? ppsh_pkg::OD_LEVEL : pad_out_in[b];
      end else begin
        // released pad: board level or pull-up
        pad_level_out[b] = board_val_in[b];
      end
    end
  end
endmodule

// ---- test/peripheral_pin_sharing_bench.sv ----
`timescale 1ns/1ps
module peripheral_pin_sharing_bench;
  typedef struct packed {
    logic [9:0] mc; logic [9:0] ac; logic [2:0] moe; logic [2:0] mo; logic [5:0] ioe;
    logic [5:0] io;
  } ppsh_row_type;
  // ****************************************************
  // rows: m ctl, async ctl, expected m and i drive
  // ****************************************************
  localparam ppsh_row_type ROWS [8] = '{
    {10'h000, 10'h000, 3'h0, 3'h5, 6'h00, 6'h00}, {10'h180, 10'h140, 3'h0, 3'h7, 6'h00, 6'h02},
    {10'h008, 10'h002, 3'h7, 3'h0, 6'h20, 6'h00}, {10'h001, 10'h014, 3'h7, 3'h0, 6'h00, 6'h04},
    {10'h004, 10'h02a, 3'h7, 3'h0, 6'h00, 6'h20}, {10'h040, 10'h281, 3'h4, 3'h1, 6'h04, 6'h10},
    {10'h020, 10'h000, 3'h0, 3'h1, 6'h00, 6'h00}, {10'h1b8, 10'h000, 3'h1, 3'h6, 6'h00, 6'h00}};
  localparam logic [26:0] PAT [3] = '{27'h2b3c5a6, 27'h2b3c5a6, 27'h54c3a59};
  logic clk_sys_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [26:0] dat = '0, dir = '0, brd = '1, lvl;
  wire [26:0] pins, pout, poen;
  logic ss_rx_en = 0, ss_tx_en = 0, ss_tx_d = 0, ss_ext = 0, ss_ckoe = 0, ss_ckd = 0;
  logic ss_rx, ss_sck, cnt_en = 0, ph_a, ph_b, zr, tw_en = 0, tw_sda_lo = 0, tw_scl_lo = 0;
  logic tw_sda, tw_scl, fr_sel = 0, fr_ck, cv_sel = 0, cv_trg;
  logic [2:0] trg_en = '0, trg;
  logic [15:0] irq_en = '0, irq;
  logic [1:0] a_tx_en = 0, a_tx_d = 0, a_ckoe = 0, a_ckd = 0, a_ext = 0, a_rx, a_ck;
  int num_errors = 0, cmp_count = 0, cyc = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  ppsh_board_model #(.OD_MASK(27'h18)) ppsh_board_model_i (.pad_out_in(pout),
    .pad_oe_n_in(poen), .board_val_in(brd), .pad_level_out(pins));
  ppsh_pin_sharing ppsh_pin_sharing_i (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in),
    .port_group_m_pad_in(pins[2:0]), .port_group_m_pad_out(pout[2:0]),
    .port_group_m_pad_oe_n_out(poen[2:0]), .port_group_l_pad_in(pins[4:3]),
    .port_group_l_pad_out(pout[4:3]), .port_group_l_pad_oe_n_out(poen[4:3]),
    .port_group_k_pad_in(pins[12:5]), .port_group_k_pad_out(pout[12:5]),
    .port_group_k_pad_oe_n_out(poen[12:5]), .port_group_j_pad_in(pins[20:13]),
    .port_group_j_pad_out(pout[20:13]), .port_group_j_pad_oe_n_out(poen[20:13]),
    .port_group_i_pad_in(pins[26:21]), .port_group_i_pad_out(pout[26:21]),
    .port_group_i_pad_oe_n_out(poen[26:21]), .port_group_m_data_in(dat[2:0]),
    .port_group_m_dir_in(dir[2:0]), .port_group_l_data_in(dat[4:3]),
    .port_group_l_dir_in(dir[4:3]), .port_group_k_data_in(dat[12:5]),
    .port_group_k_dir_in(dir[12:5]), .port_group_j_data_in(dat[20:13]),
    .port_group_j_dir_in(dir[20:13]), .port_group_i_data_in(dat[26:21]),
    .port_group_i_dir_in(dir[26:21]), .port_pad_level_out(lvl),
    .sync_serial_rx_en_in(ss_rx_en), .sync_serial_tx_en_in(ss_tx_en),
    .sync_serial_tx_data_in(ss_tx_d), .sync_serial_ext_clk_mode_in(ss_ext),
    .sync_serial_clk_oe_in(ss_ckoe), .sync_serial_clk_drive_in(ss_ckd),
    .sync_serial_rx_out(ss_rx), .sync_serial_shift_clock_out(ss_sck),
    .updown_counter_en_in(cnt_en), .updown_counter_phase_a_out(ph_a),
    .updown_counter_phase_b_out(ph_b), .updown_counter_zero_out(zr),
    .pulse_gen_trig_en_in(trg_en), .pulse_gen_ext_trigger_out(trg),
    .two_wire_en_in(tw_en), .two_wire_sda_low_in(tw_sda_lo), .two_wire_scl_low_in(tw_scl_lo),
    .two_wire_sda_out(tw_sda), .two_wire_scl_out(tw_scl), .ext_irq_en_in(irq_en),
    .ext_interrupt_inputs_out(irq), .freerun_ext_clk_sel_in(fr_sel),
    .freerun_ext_clock_out(fr_ck), .converter_trig_sel_in(cv_sel),
    .converter_ext_trigger_out(cv_trg), .async_serial_tx_en_in(a_tx_en),
    .async_serial_tx_data_in(a_tx_d), .async_serial_clk_oe_in(a_ckoe),
    .async_serial_clk_drive_in(a_ckd), .async_serial_ext_clk_in(a_ext),
    .async_serial_rx_data_out(a_rx), .async_serial_clock_pin_out(a_ck));
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) begin
      @(posedge clk_sys_in);
      #1;
    end
  endtask
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      complete_run();
    end
  end
  initial begin
    step(5);
    chk(poen, 27'h7ffffff);
    chk(pout, 27'h0);
    rstn_in = 1'b1;
    dat[2:0] = 3'h5;
    dir[2:0] = 3'h7;
    dir[26:21] = 6'h3f;
    foreach (ROWS[r]) begin
      {ss_rx_en, ss_tx_en, ss_tx_d, ss_ext, ss_ckoe, ss_ckd, cnt_en, trg_en} = ROWS[r].mc;
      {a_tx_en, a_tx_d, a_ckoe, a_ckd, a_ext} = ROWS[r].ac;
      step(1);
      chk(poen[2:0], ROWS[r].moe);
      chk(pout[2:0] & ~ROWS[r].moe, ROWS[r].mo);
      chk(poen[26:21], ROWS[r].ioe);
      chk(pout[26:21] & ~ROWS[r].ioe, ROWS[r].io);
    end
    $display("test drive rows done");
    // pads used as inputs: software keeps the port driver off
    dir = '0;
    {ss_tx_en, ss_ckoe, a_tx_en, a_ckoe} = '0;
    for (int p = 0; p < 3; p++) begin
      brd = PAT[p];
      {ss_rx_en, ss_ext, cnt_en, fr_sel, cv_sel} = (p == 1) ? 5'h0 : 5'h1f;
      trg_en = (p == 1) ? 3'h0 : 3'h5;
      irq_en = (p == 1) ? 16'h0 : 16'hc3f5;
      a_ext = (p == 1) ? 2'h0 : 2'h2;
      step(4);
      chk(lvl, brd);
      chk({ss_rx, ss_sck}, {ss_rx_en & brd[0], ss_ext & brd[2]});
      chk({ph_a, ph_b, zr}, {3{cnt_en}} & {brd[0], brd[1], brd[2]});
      chk(trg, trg_en & brd[2:0]);
      chk(irq, irq_en & brd[20:5]);
      chk({fr_ck, cv_trg}, {fr_sel & brd[11], cv_sel & brd[12]});
      chk({a_rx, a_ck}, {brd[24], brd[21], a_ext & {brd[26], brd[23]}});
    end
    $display("test input paths done");
    brd = '1;
    {tw_en, tw_sda_lo, tw_scl_lo} = 3'b110;
    step(4);
    chk({poen[4:3], pout[4:3]}, 4'h8);
    chk({tw_scl, tw_sda}, 2'h2);
    {tw_en, dir[4:3], dat[4:3]} = 5'b01101;
    step(1);
    chk({poen[4:3], pout[4:3]}, 4'h4);
    dat[4:3] = 2'b10;
    step(1);
    chk({poen[4:3], pout[4:3]}, 4'h8);
    $display("test two wire done");
    {ss_tx_en, ss_tx_d, a_tx_en, a_tx_d, dir} = {2'h3, 4'hf, 27'h7ffffff};
    dat[20:5] = 16'h9c63;
    step(4);
    chk(pout[20:5], 16'h9c63);
    chk(poen[20:5], 16'h0000);
    rstn_in = 1'b0;
    #1;
    chk(poen, 27'h7ffffff);
    chk(irq, 16'h0000);
    chk(pout, 27'h0);
    step(1);
    rstn_in = 1'b1;
    step(1);
    chk(poen[22], 1'b0);
    $display("test mid reset done");
    complete_run();
  end
endmodule
